// ===== rtl/vbapb_bridge.sv
`timescale 1ns/10ps
// How it works
// - Odd parity per driven byte
// - Parity always over full 32 bits
// - Generate when driving, check when receiving
// - Error raises front-end interrupt, latched in register
// - Register selected by switch address match
// - Register answers A32/A24, D32/D16
// - Clear bit clears all error latches
// - Data fault latches first error only
// - Data checked at strobe/acknowledge when involved
// - Address fault latches first error only
// - Address checked each strobe, block first only
// - Force bit corrupts parity on chosen bus
// - Global check bit gates data checking
// - Report enable gates interrupt only
// - Local-only bit limits front-end access
// - Request 3 and grant chain passed through
// - Release request shown on request 2
// - Unused request lines held inactive
// - No read-modify-write to front end
module vbapb_bridge
(
    input  wire logic        core_clk_in,      // System clock
    input  wire logic        rst_in,           // Backplane reset, async high
    input  wire logic        clk_en_in,        // Freezes state while low
    input  wire logic [29:0] csr_switch_in,    // Switch packs, address A31..A2
    // Backplane side (pins)
    input  wire logic [31:0] bp_addr_in,       // Address lines
    input  wire logic [3:0]  bp_addr_par_in,   // Address parity
    input  wire logic [5:0]  bp_am_in,         // Address modifier
    input  wire logic        bp_am_par_in,     // Modifier parity
    input  wire logic [31:0] bp_data_in,       // Data lines
    input  wire logic [3:0]  bp_data_par_in,   // Data parity
    input  wire logic        bp_as_n_in,       // Address strobe
    input  wire logic        bp_ds_n_in,       // Data strobe
    input  wire logic        bp_write_n_in,    // Write low
    input  wire logic        bp_dtack_n_in,    // Acknowledge
    input  wire logic        bp_bg3_n_in,      // Grant chain in
    input  wire logic        bp_ror_n_in,      // Release requested by another
    // Attached board side
    input  wire logic [31:0] vb_addr_in,       // Board address
    input  wire logic [5:0]  vb_am_in,         // Board modifier
    input  wire logic [31:0] vb_data_in,       // Board write data
    input  wire logic        vb_drive_in,      // Board is master driving
    input  wire logic        vb_fe_target_in,  // Board targets front end
    input  wire logic        vb_rmw_in,        // Board cycle is read-modify-write
    input  wire logic        vb_br3_n_in,      // Board request level 3
    input  wire logic        vb_bg3out_n_in,   // Board passes grant on
    output logic [31:0]      bp_addr_out,      // Driven address
    output logic [3:0]       bp_addr_par_out,  // Driven address parity
    output logic [5:0]       bp_am_out,        // Driven modifier
    output logic             bp_am_par_out,    // Driven modifier parity
    output logic [31:0]      bp_data_out,      // Driven data / register read
    output logic [3:0]       bp_data_par_out,  // Driven data parity
    output logic             bp_data_oe_out,   // Data drive enable
    output logic             bp_dtack_oe_out,  // Register acknowledge
    output logic             bp_br3_oe_out,    // Backplane request pulled low
    output logic             bp_bg3out_n_out,  // Grant chain out
    output logic             vb_bg3in_n_out,   // Grant to board
    output logic             vb_br2_n_out,     // Release request to board
    output logic             vb_br01_n_out,    // Levels 0/1 held inactive
    output logic             vb_fe_allow_out,  // Front-end cycle permitted
    output logic             fe_irq17_out      // Front-end parity interrupt
);
    // Synchronised backplane pins (two stages each)
    logic [31:0] addr_s1, addr_s2;
    logic [3:0]  apar_s1, apar_s2;
    logic [5:0]  am_s1, am_s2;
    logic        ampar_s1, ampar_s2;
    logic [31:0] data_s1, data_s2;
    logic [3:0]  dpar_s1, dpar_s2;
    logic [5:0]  ctl_s1, ctl_s2;       // as, ds, wr, dtack, bg3, ror
    logic        as_d_reg, ds_d_reg, dt_d_reg; // Edge history
    // Register state
    logic        local_only_reg, report_en_reg, global_check_reg;
    logic        force_bad_reg, force_target_reg;
    logic        addr_fault_reg, data_fault_reg;
    logic        involved_reg;     // This board is party to current cycle
    logic        blt_seen_reg;     // First block address already checked
    logic        csr_hit_reg;      // Current cycle selects the register
    // Parity units
    vbapb_par_if rx_a_if ();
    vbapb_par_if rx_d_if ();
    vbapb_par_if tx_a_if ();
    vbapb_par_if tx_d_if ();
    vbapb_parity u_rx_a (.p(rx_a_if));
    vbapb_parity u_rx_d (.p(rx_d_if));
    vbapb_parity u_tx_a (.p(tx_a_if));
    vbapb_parity u_tx_d (.p(tx_d_if));

    // Modifier parity: odd over the six lines
    function automatic logic am_odd(input logic [5:0] am);
        am_odd = ~(^am);
    endfunction
    // 24-bit space recognised from the modifier
    function automatic logic am_is_a24(input logic [5:0] am);
        am_is_a24 = ((am & vbapb_pkg::AM_A24_MASK) == vbapb_pkg::AM_A24_MATCH);
    endfunction
    // Block transfer modifier
    function automatic logic am_is_blt(input logic [5:0] am);
        am_is_blt = (am[1:0] == vbapb_pkg::AM_BLT_LOW);
    endfunction

    // Strobes, decoded from the synchronised control group
    logic as_act, ds_act, wr, dt_act, as_rise, ds_rise, dt_rise;
    assign as_act  = ~ctl_s2[0];
    assign ds_act  = ~ctl_s2[1];
    assign wr      = ~ctl_s2[2];
    assign dt_act  = ~ctl_s2[3];
    assign as_rise = as_act & ~as_d_reg;
    assign ds_rise = ds_act & ~ds_d_reg;
    assign dt_rise = dt_act & ~dt_d_reg;

    assign rx_a_if.word = addr_s2;
    assign rx_d_if.word = data_s2;
    // full 32 bits even for A24/D16
    assign tx_a_if.word = vb_addr_in;
    assign tx_d_if.word = vb_data_in;

    // Address compare: A24 compares A23..A2 with the low 22 bits of the switches
    logic addr_match;
    always_comb
    begin
        if (am_is_a24(am_s2))
            addr_match = (addr_s2[23:vbapb_pkg::SW_LSB] == csr_switch_in[21:0]);
        else
            addr_match = (addr_s2[31:vbapb_pkg::SW_LSB] == csr_switch_in);
    end

    // Error detection on synchronised samples
    logic addr_err, data_err;
    always_comb
    begin
        // checked while strobe low, block runs first only
        addr_err = as_act && !blt_seen_reg
                   && ((rx_a_if.par_gen != apar_s2) || (am_odd(am_s2) != ampar_s2));
        // DS for writes, DTACK for reads, involved only
        data_err = involved_reg && global_check_reg
                   && ((wr && ds_rise) || (!wr && dt_rise))
                   && (rx_d_if.par_gen != dpar_s2);
    end

    // Pin synchronisers, two stages
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            addr_s1 <= '0; addr_s2 <= '0; apar_s1 <= '0; apar_s2 <= '0;
            am_s1 <= '0; am_s2 <= '0; ampar_s1 <= 1'b0; ampar_s2 <= 1'b0;
            data_s1 <= '0; data_s2 <= '0; dpar_s1 <= '0; dpar_s2 <= '0;
            ctl_s1 <= '1; ctl_s2 <= '1;
        end
        else if (clk_en_in)
        begin
            addr_s1 <= bp_addr_in;     addr_s2 <= addr_s1;
            apar_s1 <= bp_addr_par_in; apar_s2 <= apar_s1;
            am_s1 <= bp_am_in;         am_s2 <= am_s1;
            ampar_s1 <= bp_am_par_in;  ampar_s2 <= ampar_s1;
            data_s1 <= bp_data_in;     data_s2 <= data_s1;
            dpar_s1 <= bp_data_par_in; dpar_s2 <= dpar_s1;
            ctl_s1 <= {bp_ror_n_in, bp_bg3_n_in, bp_dtack_n_in,
                       bp_write_n_in, bp_ds_n_in, bp_as_n_in};
            ctl_s2 <= ctl_s1;
        end
    end

    // Strobe history and cycle tracking
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            as_d_reg <= 1'b0; ds_d_reg <= 1'b0; dt_d_reg <= 1'b0;
            involved_reg <= 1'b0; blt_seen_reg <= 1'b0; csr_hit_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            as_d_reg <= as_act;
            ds_d_reg <= ds_act;
            dt_d_reg <= dt_act;
            if (!as_act)
            begin
                // Cycle ended: block run over
                blt_seen_reg <= 1'b0;
                involved_reg <= vb_drive_in;
                csr_hit_reg  <= 1'b0;
            end
            else if (as_rise)
            begin
                blt_seen_reg <= am_is_blt(am_s2);
                csr_hit_reg  <= addr_match;
                // Party to the transfer: we drive or we are addressed
                involved_reg <= vb_drive_in | addr_match;
            end
        end
    end

    // Control bits written by software
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            local_only_reg   <= vbapb_pkg::LOCAL_ONLY_RST;
            report_en_reg    <= vbapb_pkg::REPORT_EN_RST;
            global_check_reg <= vbapb_pkg::GLOBAL_CHECK_RST;
            force_bad_reg    <= 1'b0;
            force_target_reg <= 1'b0;
        end
        else if (clk_en_in && csr_hit_reg && wr && ds_rise)
        begin
            // D16 writes land in the low word, all bits live there
            local_only_reg   <= data_s2[vbapb_pkg::BIT_LOCAL_ONLY];
            report_en_reg    <= data_s2[vbapb_pkg::BIT_REPORT_EN];
            global_check_reg <= data_s2[vbapb_pkg::BIT_GLOBAL_CHECK];
            force_bad_reg    <= data_s2[vbapb_pkg::BIT_FORCE_BAD];
            force_target_reg <= data_s2[vbapb_pkg::BIT_FORCE_TARGET];
        end
    end

    // Error latches; a new error in the clear cycle is kept
    logic clr_pulse;
    assign clr_pulse = csr_hit_reg && wr && ds_rise
                       && data_s2[vbapb_pkg::BIT_ERROR_CLEAR];
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            addr_fault_reg <= 1'b0;
            data_fault_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            // first address error, set beats clear
            if (addr_err)
                addr_fault_reg <= 1'b1;
            else if (clr_pulse)
                addr_fault_reg <= 1'b0;
            // first data error, set beats clear
            if (data_err)
                data_fault_reg <= 1'b1;
            else if (clr_pulse)
                data_fault_reg <= 1'b0;
        end
    end

    // Register read image
    logic [31:0] csr_image;
    always_comb
    begin
        // unused bits and clear bit read zero
        csr_image = vbapb_pkg::ZERO_WORD;
        csr_image[vbapb_pkg::BIT_LOCAL_ONLY]   = local_only_reg;
        csr_image[vbapb_pkg::BIT_REPORT_EN]    = report_en_reg;
        csr_image[vbapb_pkg::BIT_GLOBAL_CHECK] = global_check_reg;
        csr_image[vbapb_pkg::BIT_FORCE_BAD]    = force_bad_reg;
        csr_image[vbapb_pkg::BIT_FORCE_TARGET] = force_target_reg;
        csr_image[vbapb_pkg::BIT_ADDR_FAULT]   = addr_fault_reg;
        csr_image[vbapb_pkg::BIT_DATA_FAULT]   = data_fault_reg;
    end

    // Backplane drive with parity, register read-back and acknowledge
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bp_addr_out <= '0; bp_addr_par_out <= '0; bp_am_out <= '0;
            bp_am_par_out <= 1'b0; bp_data_out <= '0; bp_data_par_out <= '0;
            bp_data_oe_out <= 1'b0; bp_dtack_oe_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            bp_addr_out <= vb_addr_in;
            bp_am_out   <= vb_am_in;
            // odd byte parity; inverted on address side when forced with target zero
            bp_addr_par_out <= tx_a_if.par_gen
                               ^ {4{force_bad_reg & ~force_target_reg}};
            bp_am_par_out   <= am_odd(vb_am_in) ^ (force_bad_reg & ~force_target_reg);
            bp_dtack_oe_out <= csr_hit_reg && ds_act;
            if (csr_hit_reg && !wr && ds_act)
            begin
                // Register read: our own data, our own parity
                bp_data_out     <= csr_image;
                bp_data_par_out <= {4{force_bad_reg & force_target_reg}}
                                   ^ {~(^csr_image[31:24]), ~(^csr_image[23:16]),
                                      ~(^csr_image[15:8]), ~(^csr_image[7:0])};
                bp_data_oe_out  <= 1'b1;
            end
            else
            begin
                // data side inversion when target is one
                bp_data_out     <= vb_data_in;
                bp_data_par_out <= tx_d_if.par_gen ^ {4{force_bad_reg & force_target_reg}};
                bp_data_oe_out  <= vb_drive_in;
            end
        end
    end

    // Arbitration pass-through and front-end gating
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bp_br3_oe_out <= 1'b0; bp_bg3out_n_out <= 1'b1; vb_bg3in_n_out <= 1'b1;
            vb_br2_n_out <= 1'b1; vb_br01_n_out <= 1'b1; vb_fe_allow_out <= 1'b0;
            fe_irq17_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            // level 3 only, passed straight from the board request
            bp_br3_oe_out   <= ~vb_br3_n_in;
            vb_bg3in_n_out  <= ctl_s2[4];
            bp_bg3out_n_out <= vb_bg3out_n_in;
            vb_br2_n_out    <= ctl_s2[5];
            // levels 0 and 1 held inactive
            vb_br01_n_out   <= 1'b1;
            // front end only when allowed, never RMW
            vb_fe_allow_out <= vb_fe_target_in && !local_only_reg && !vb_rmw_in;
            // front-end interrupt, gated by report enable
            fe_irq17_out    <= report_en_reg && (addr_fault_reg || data_fault_reg);
        end
    end
endmodule

// ===== rtl/vbapb_par_if.sv
`timescale 1ns/10ps
// Parity generator/checker hookup for one 32-bit field
interface vbapb_par_if;
    logic [31:0] word;     // Field value
    logic [3:0]  par_gen;  // Odd parity per byte
    modport gen (input word, output par_gen);
    modport user (output word, input par_gen);
endinterface

// ===== rtl/vbapb_parity.sv
`timescale 1ns/10ps
// Odd parity per byte of a 32-bit field
module vbapb_parity
(
    vbapb_par_if.gen p
);
    genvar g;
    // One bit per byte, full width even for A24/D16
    generate
        for (g = 0; g < vbapb_pkg::DATA_BYTES; g = g + 1)
        begin : g_byte
            assign p.par_gen[g] = ~(^p.word[8*g +: 8]);
        end
    endgenerate
endmodule

// ===== rtl/vbapb_pkg.sv
package vbapb_pkg;
    // Control/status bit positions
    localparam int BIT_LOCAL_ONLY   = 0;
    localparam int BIT_REPORT_EN    = 1;
    localparam int BIT_GLOBAL_CHECK = 2;
    localparam int BIT_FORCE_BAD    = 3;
    localparam int BIT_FORCE_TARGET = 4;
    localparam int BIT_ADDR_FAULT   = 5;
    localparam int BIT_DATA_FAULT   = 6;
    localparam int BIT_ERROR_CLEAR  = 11;
    // Widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int AM_W   = 6;
    localparam int DATA_BYTES = 4;
    localparam int ADDR_BYTES = 4;
    // Switch-compared address bits: A31..A2
    localparam int SW_LSB = 2;
    // Reset values of writable bits: checks and reporting on, front end reachable
    localparam logic REPORT_EN_RST    = 1'b1;
    localparam logic GLOBAL_CHECK_RST = 1'b1;
    localparam logic LOCAL_ONLY_RST   = 1'b0;
    // Standard 24-bit address modifier codes (0x38 to 0x3F)
    localparam logic [5:0] AM_A24_MASK  = 6'h38;
    localparam logic [5:0] AM_A24_MATCH = 6'h38;
    // Standard 32-bit address modifier codes (0x0x)
    localparam logic [5:0] AM_A32_MATCH = 6'h08;
    // Block transfer modifiers have low two bits 2'b11
    localparam logic [1:0] AM_BLT_LOW   = 2'h3;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
endpackage

// ===== verification/tb_vme_board_adapter_parity_bridge.sv
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module tb_vme_board_adapter_parity_bridge;
    logic        core_clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1;
    logic [29:0] csr_switch_in = '0;
    logic [31:0] bp_addr_in = '0, bp_data_in = '0, vb_addr_in, vb_data_in, rd, csr;
    logic [3:0]  bp_addr_par_in = 4'hF, bp_data_par_in = 4'hF;
    logic [5:0]  bp_am_in = 6'h09, vb_am_in, bp_am_out;
    logic        bp_am_par_out, bp_br3_oe_out, bp_bg3out_n_out;
    logic        bp_am_par_in = 1'b0, bp_as_n_in = 1'b1, bp_ds_n_in = 1'b1;
    logic        bp_write_n_in = 1'b1, bp_bg3_n_in = 1'b1, bp_ror_n_in = 1'b1, got_ack;
    logic        vb_drive_in, vb_fe_target_in, vb_rmw_in, vb_br3_n_in, vb_bg3out_n_in;
    logic [31:0] bp_addr_out, bp_data_out;
    logic [3:0]  bp_addr_par_out, bp_data_par_out;
    logic        bp_data_oe_out, bp_dtack_oe_out, vb_bg3in_n_out, vb_br2_n_out;
    logic        vb_br01_n_out, vb_fe_allow_out, fe_irq17_out;
    wire  logic  bp_dtack_n_in = ~bp_dtack_oe_out;
    int          mismatches = 0, cmp_count = 0, cycles = 0, m, seed;
    always #5 core_clk_in = ~core_clk_in;
    vbapb_bridge u_dut (.core_clk_in, .rst_in, .clk_en_in, .csr_switch_in, .bp_addr_in,
        .bp_addr_par_in, .bp_am_in, .bp_am_par_in, .bp_data_in, .bp_data_par_in, .bp_as_n_in,
        .bp_ds_n_in, .bp_write_n_in, .bp_dtack_n_in, .bp_bg3_n_in, .bp_ror_n_in, .vb_addr_in,
        .vb_am_in, .vb_data_in, .vb_drive_in, .vb_fe_target_in, .vb_rmw_in, .vb_br3_n_in,
        .vb_bg3out_n_in, .bp_addr_out, .bp_addr_par_out, .bp_am_out, .bp_am_par_out,
        .bp_data_out, .bp_data_par_out, .bp_data_oe_out, .bp_dtack_oe_out, .bp_br3_oe_out,
        .bp_bg3out_n_out, .vb_bg3in_n_out, .vb_br2_n_out, .vb_br01_n_out, .vb_fe_allow_out,
        .fe_irq17_out);
    vbapb_board_model u_board (.core_clk_in, .bg3in_n_in(vb_bg3in_n_out),
        .addr_out(vb_addr_in), .am_out(vb_am_in), .data_out(vb_data_in),
        .drive_out(vb_drive_in), .fe_out(vb_fe_target_in), .rmw_out(vb_rmw_in),
        .br3_n_out(vb_br3_n_in), .bg3out_n_out(vb_bg3out_n_in));
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            $display("MISMATCH %0t timeout", $time);
            wrap_up;
        end
    end
    function automatic logic [3:0] opar(input logic [31:0] w);
        for (int i = 0; i < 4; i++)
            opar[i] = ~^w[8*i+:8];
    endfunction
    // One backplane cycle; bad[0] spoils address parity, bad[1] data parity
    task automatic bus(input logic [31:0] a, input logic [5:0] am, input logic wr,
                       input logic [31:0] d, input logic [1:0] bad);
        int n;
        @(posedge core_clk_in);
        bp_addr_in     <= a;
        bp_addr_par_in <= opar(a) ^ {3'h0, bad[0]};
        bp_am_in       <= am;
        bp_am_par_in   <= ~^am;
        bp_data_in     <= d;
        bp_data_par_in <= opar(d) ^ {3'h0, bad[1]};
        bp_write_n_in  <= ~wr;
        bp_as_n_in     <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        bp_ds_n_in <= 1'b0;
        n = 0;
        got_ack = 1'b0;
        while (!got_ack && n < 12)
        begin
            @(posedge core_clk_in);
            got_ack = (bp_dtack_oe_out === 1'b1);
            rd = bp_data_out;
            n++;
        end
        bp_ds_n_in <= 1'b1;
        bp_as_n_in <= 1'b1;
        bp_data_in <= ~d;
        repeat (6) @(posedge core_clk_in);
    endtask
    task automatic wreg(input int d);
        bus(csr, 6'h09, 1'b1, 32'(d), 2'h0);
        m = (m & 32'h60) | (d & 32'h1F);
        if (d[11])
            m = m & 32'h1F;
    endtask
    task automatic rreg(input logic [5:0] am, input logic [31:0] a);
        bus(a, am, 1'b0, 32'h0000_0000, 2'h0);
        `CHK(got_ack, 1'b1)
        `CHK(rd, 32'(m))
    endtask
    initial
    begin
        seed = 32'h2079;
        csr_switch_in = 30'($random(seed));
        csr = {csr_switch_in, 2'h0};
        m = 32'h6;
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        rreg(6'h09, csr);
        $display("reset values done");
        // Random A32 writes read back through the short space
        repeat (4)
        begin
            wreg($random(seed) & 32'hFFFF_FFF7);
            rreg(6'h39, {~csr[31:24], csr[23:0]});
        end
        bus(csr + 32'h4, 6'h09, 1'b0, 32'h0000_0000, 2'h0);
        `CHK(got_ack, 1'b0)
        $display("access done");
        // Address fault then data fault, both latched; interrupt checked after the address fault
        wreg(32'h6);
        bus(csr + 32'h4, 6'h09, 1'b0, 32'h0000_0000, 2'h1);
        m = m | 32'h20;
        `CHK(fe_irq17_out, 1'b1)
        rreg(6'h09, csr);
        bus(csr, 6'h09, 1'b1, 32'h6, 2'h2);
        m = m | 32'h40;
        rreg(6'h09, csr);
        wreg(32'h806);
        rreg(6'h09, csr);
        `CHK(fe_irq17_out, 1'b0)
        // Reporting off keeps the latch but no interrupt
        wreg(32'h4);
        bus(csr + 32'h4, 6'h09, 1'b0, 32'h0000_0000, 2'h1);
        m = m | 32'h20;
        `CHK(fe_irq17_out, 1'b0)
        rreg(6'h09, csr);
        // Global data check off: bad data parity ignored
        wreg(32'h802);
        bus(csr, 6'h09, 1'b1, 32'h2, 2'h2);
        rreg(6'h09, csr);
        $display("faults done");
        // Block transfer: a later bad address is not checked
        wreg(32'h6);
        bp_am_in       <= 6'h0B;
        bp_am_par_in   <= ~^6'h0B;
        bp_addr_in     <= csr + 32'h4;
        bp_addr_par_in <= opar(csr + 32'h4);
        bp_as_n_in     <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        bp_addr_in     <= csr + 32'h8;
        bp_addr_par_in <= ~opar(csr + 32'h8);
        repeat (4) @(posedge core_clk_in);
        bp_as_n_in <= 1'b1;
        repeat (6) @(posedge core_clk_in);
        rreg(6'h09, csr);
        // Local-only and rmw both bar the front end
        wreg(32'h7);
        u_board.master(csr + 32'h10, $random(seed), 1'b1, 1'b0, 1'b1);
        repeat (4) @(posedge core_clk_in);
        `CHK(vb_fe_allow_out, 1'b0)
        wreg(32'h6);
        `CHK(vb_fe_allow_out, 1'b1)
        u_board.master(csr + 32'h10, $random(seed), 1'b1, 1'b1, 1'b1);
        repeat (4) @(posedge core_clk_in);
        `CHK(vb_fe_allow_out, 1'b0)
        u_board.master(32'h0000_0000, 32'h0000_0000, 1'b0, 1'b0, 1'b0);
        bp_ror_n_in <= 1'b0;
        bp_bg3_n_in <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        `CHK(vb_br2_n_out, 1'b0)
        `CHK(vb_br01_n_out, 1'b1)
        `CHK(vb_bg3in_n_out, 1'b0)
        `CHK(bp_br3_oe_out, 1'b0)
        `CHK(bp_bg3out_n_out, 1'b0)
        bp_ror_n_in <= 1'b1;
        bp_bg3_n_in <= 1'b1;
        $display("arbitration done");
        // Forced wrong parity, data then address target
        wreg(32'h1E);
        u_board.master(csr + 32'h10, $random(seed), 1'b0, 1'b0, 1'b1);
        repeat (6) @(posedge core_clk_in);
        `CHK(^{bp_data_out[7:0], bp_data_par_out[0]}, 1'b0)
        `CHK(^{bp_am_out, bp_am_par_out}, 1'b1)
        wreg(32'hE);
        `CHK(^{bp_addr_out[7:0], bp_addr_par_out[0]}, 1'b0)
        `CHK(^{bp_am_out, bp_am_par_out}, 1'b0)
        $display("forced parity done");
        wrap_up;
    end
endmodule

// ===== verification/vbapb_board_model.sv
`timescale 1ns/10ps
// Attached standard board: master fields and level 3 arbitration only
module vbapb_board_model
(
    input  wire logic   core_clk_in,
    input  wire logic   bg3in_n_in,
    output logic [31:0] addr_out,
    output logic [5:0]  am_out,
    output logic [31:0] data_out,
    output logic        drive_out,
    output logic        fe_out,
    output logic        rmw_out,
    output logic        br3_n_out,
    output logic        bg3out_n_out
);
    initial
    begin
        addr_out  = 32'h0000_0000;
        am_out    = 6'h09;
        data_out  = 32'h0000_0000;
        drive_out = 1'b0;
        fe_out    = 1'b0;
        rmw_out   = 1'b0;
        br3_n_out = 1'b1;
    end
    assign bg3out_n_out = bg3in_n_in | ~br3_n_out;
    // Start or end a master phase; released lines flip, never hold
    task automatic master(input logic [31:0] a, input logic [31:0] d, input logic fe,
                          input logic rmw, input logic on);
        @(posedge core_clk_in);
        drive_out <= on;
        fe_out    <= fe;
        rmw_out   <= rmw;
        addr_out  <= on ? a : ~addr_out;
        data_out  <= on ? d : ~data_out;
    endtask
endmodule

// ===== verification/vbapb_bridge_props.sv
`timescale 1ns/10ps
// Port-level checks of the parity bridge
module vbapb_bridge_props
(
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        clk_en_in,
    input wire logic [29:0] csr_switch_in,
    input wire logic [31:0] bp_addr_in,
    input wire logic [5:0]  bp_am_in,
    input wire logic [31:0] bp_data_in,
    input wire logic        bp_ds_n_in,
    input wire logic        bp_write_n_in,
    input wire logic        bp_ror_n_in,
    input wire logic        vb_drive_in,
    input wire logic        vb_rmw_in,
    input wire logic [31:0] bp_addr_out,
    input wire logic [3:0]  bp_addr_par_out,
    input wire logic [31:0] bp_data_out,
    input wire logic [3:0]  bp_data_par_out,
    input wire logic        bp_data_oe_out,
    input wire logic        bp_dtack_oe_out,
    input wire logic        vb_br2_n_out,
    input wire logic        vb_br01_n_out,
    input wire logic        vb_fe_allow_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    // Register hit in either address space
    wire logic sel_hit = (bp_addr_in[31:2] == csr_switch_in) ||
        (((bp_am_in & vbapb_pkg::AM_A24_MASK) == vbapb_pkg::AM_A24_MATCH) &&
        (bp_addr_in[23:2] == csr_switch_in[21:0]));
    // Wrong parity is legal once forcing is written, so parity checks stop
    logic forced_reg;
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            forced_reg <= 1'b0;
        else if (!bp_ds_n_in && !bp_write_n_in && sel_hit && bp_data_in[3])
            forced_reg <= 1'b1;
    end
    // Every byte with its bit has an odd count of ones
    function automatic logic odd_ok(input logic [31:0] w, input logic [3:0] p);
        return &{^{w[31:24], p[3]}, ^{w[23:16], p[2]}, ^{w[15:8], p[1]}, ^{w[7:0], p[0]}};
    endfunction
    sequence s_ror_low;
        (!bp_ror_n_in && clk_en_in) [*5];
    endsequence
    sequence s_drive;
        (vb_drive_in && clk_en_in) [*3];
    endsequence
    a_low_levels_idle: assert property (vb_br01_n_out)
        else $error("levels 0/1 not inactive");
    a_ror_shown: assert property (s_ror_low |-> !vb_br2_n_out)
        else $error("release request not passed on");
    a_ror_quiet: assert property ((bp_ror_n_in && clk_en_in) [*5] |-> vb_br2_n_out)
        else $error("release request without cause");
    a_rmw_no_fe: assert property ((vb_rmw_in && clk_en_in) [*3] |-> !vb_fe_allow_out)
        else $error("front end allowed for rmw");
    a_ack_after_ds: assert property (bp_dtack_oe_out |-> !($past(bp_ds_n_in) &&
        $past(bp_ds_n_in, 2) && $past(bp_ds_n_in, 3) && $past(bp_ds_n_in, 4)))
        else $error("acknowledge without data strobe");
    a_ack_needs_hit: assert property ($rose(bp_dtack_oe_out) |-> $past(sel_hit, 2))
        else $error("acknowledge without address match");
    a_addr_par_odd: assert property (disable iff (rst_in || forced_reg)
        s_drive |-> odd_ok(bp_addr_out, bp_addr_par_out))
        else $error("address parity not odd");
    a_data_par_odd: assert property (disable iff (rst_in || forced_reg)
        bp_data_oe_out |-> odd_ok(bp_data_out, bp_data_par_out))
        else $error("data parity not odd");
endmodule
bind vbapb_bridge vbapb_bridge_props u_props (.core_clk_in, .rst_in, .clk_en_in,
    .csr_switch_in, .bp_addr_in, .bp_am_in, .bp_data_in, .bp_ds_n_in, .bp_write_n_in,
    .bp_ror_n_in, .vb_drive_in, .vb_rmw_in, .bp_addr_out, .bp_addr_par_out, .bp_data_out,
    .bp_data_par_out, .bp_data_oe_out, .bp_dtack_oe_out, .vb_br2_n_out, .vb_br01_n_out,
    .vb_fe_allow_out);
